// ### bcwb_pkg.sv
// Constants, types and field layout for the bus configuration, burst and check-value block.
// Assumes one clock and a synchronous active-high reset shared with the whole device.
// What this block does
// R01: Decode both lock bits right after reset.
// R02: Programmed lock bit stays writable until reset.
// R03: Programmed lock before reset locks permanently.
// R04: Software reset keeps the configuration source selector.
// R05: Nonvolatile program leaves loaded volatile register alone.
// R06: Nonvolatile program loads unloaded volatile register.
// R07: Nonvolatile changes act after reset, except a program while volatile is unloaded, which acts at once.
// R08: Volatile load acts from the next transaction.
// R09: Burst type one gives linear incrementing burst.
// R10: Length code 10 wraps in 8 words.
// R11: Length code 11 wraps in 16 words.
// R12: Length code 01 wraps in 32 words.
// R13: Idle cycles in 64-byte wrap hold strobe still.
// R14: Each 64-byte wrap word delivered exactly once.
// R15: Check value covers start through end inclusive.
// R16: Check value read as low and high words.
// R17: Check value is volatile, reset clears it.
// R18: Settings from nonvolatile until volatile is loaded.
// R19: Decode burst length field codes.
// R20: Lock bit zero locks, one unlocks.
// R21: Loaded flag selects the configuration source.
package bcwb_pkg;
  localparam int CFG_W = 16;
  localparam int ADDR_W = 32;
  localparam int CRC_W = 32;
  localparam int HALF_W = 16;
  localparam int LOCK_BIT = 11;
  localparam int BL_LO = 0;
  localparam int BL_HI = 1;
  localparam logic [CFG_W-1:0] CFG_FACTORY = 16'hbf8b;
  localparam logic [1:0] BL_RSVD = 2'h0;
  localparam logic [1:0] BL_64 = 2'h1;
  localparam logic [1:0] BL_16 = 2'h2;
  localparam logic [1:0] BL_32 = 2'h3;
  localparam logic [ADDR_W-1:0] MASK_16 = 32'h00000007;
  localparam logic [ADDR_W-1:0] MASK_32 = 32'h0000000f;
  localparam logic [ADDR_W-1:0] MASK_64 = 32'h0000001f;
  localparam logic [5:0] WORDS_64 = 6'h20;
  localparam logic [CRC_W-1:0] CRC_POLY = 32'h04c11db7;
  localparam logic [CRC_W-1:0] CRC_INIT = 32'hffffffff;
  typedef enum logic [1:0] {
    BCWB_UNLOCKED = 2'b00,
    BCWB_TEMP_LOCK = 2'b01,
    BCWB_PERM_LOCK = 2'b11
  } bcwb_lock_t;
  typedef enum logic [1:0] {
    BCWB_IDLE = 2'b00,
    BCWB_BURST = 2'b01,
    BCWB_DONE = 2'b11
  } bcwb_burst_t;
  typedef enum logic [1:0] {
    BCWB_CRC_IDLE = 2'b00,
    BCWB_CRC_RUN = 2'b01,
    BCWB_CRC_FIN = 2'b11
  } bcwb_crc_t;
endpackage : bcwb_pkg

// ### bcwb_top.sv
// Configuration source control, burst address sequencing and the check-value register.
// Assumes the command decoder issues one-cycle strobes on REF_CLK and supplies memory words.
module bcwb_top
  import bcwb_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic SOFT_RESET,
  input wire logic [CFG_W-1:0] NV_STORED,
  input wire logic VCR_LOAD,
  input wire logic [CFG_W-1:0] VCR_WDATA,
  input wire logic NONVOLATILE_CONFIG_REG_PROG,
  input wire logic NONVOLATILE_CONFIG_REG_ERASE,
  input wire logic [CFG_W-1:0] NONVOLATILE_CONFIG_REG_WDATA,
  input wire logic TXN_START,
  input wire logic BURST_TYPE_CMD_BIT,
  input wire logic [ADDR_W-1:0] START_ADDR,
  input wire logic WORD_REQ,
  input wire logic WORD_IDLE,
  input wire logic TXN_END,
  input wire logic CRC_GO,
  input wire logic [ADDR_W-1:0] CRC_START,
  input wire logic [ADDR_W-1:0] CRC_END,
  input wire logic [HALF_W-1:0] CRC_DATA,
  input wire logic CRC_DATA_VALID,
  output logic [CFG_W-1:0] ACTIVE_CFG,
  output logic [CFG_W-1:0] VOLATILE_CONFIG_REG,
  output logic [CFG_W-1:0] NONVOLATILE_CONFIG_REG,
  output logic CONFIG_SOURCE_SELECTOR,
  output logic [1:0] LOCK_STATE,
  output logic [ADDR_W-1:0] WORD_ADDR,
  output logic WORD_VALID,
  output logic BURST_DONE,
  output logic READ_WRITE_STROBE,
  output logic [ADDR_W-1:0] CRC_ADDR,
  output logic CRC_ADDR_VALID,
  output logic CRC_BUSY,
  output logic [HALF_W-1:0] CHECK_VALUE_LOW,
  output logic [HALF_W-1:0] CHECK_VALUE_HIGH
);

  function automatic logic [ADDR_W-1:0] wrap_mask(input logic [1:0] bl);
    unique case (bl)
      BL_16: wrap_mask = MASK_16;
      BL_32: wrap_mask = MASK_32;
      BL_64: wrap_mask = MASK_64;
      BL_RSVD: wrap_mask = MASK_32;
    endcase
  endfunction : wrap_mask

  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c,
                                                input logic [HALF_W-1:0] d);
    logic [CRC_W-1:0] r;
    r = c;
    for (int i = HALF_W - 1; i >= 0; i--)
    begin
      r = (r[CRC_W-1] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    crc_step = r;
  endfunction : crc_step

  logic [CFG_W-1:0] vcr_q, vcr_d, nv_q, nv_d, act_q, act_d;
  logic loaded_q, loaded_d, init_q, init_d;
  bcwb_lock_t lock_q, lock_d;
  logic writable;

  assign writable = (lock_q == BCWB_UNLOCKED);

  always_comb
  begin
    vcr_d = vcr_q;
    nv_d = nv_q;
    loaded_d = loaded_q;
    lock_d = lock_q;
    init_d = 1'b0;
    act_d = act_q;
    if (init_q)
    begin
      nv_d = NV_STORED;
      vcr_d = NV_STORED;
      act_d = NV_STORED; // R18
      if (NV_STORED[LOCK_BIT] && vcr_q[LOCK_BIT])
      begin
        lock_d = BCWB_UNLOCKED; // R01 R20
      end
      else if (NV_STORED[LOCK_BIT])
      begin
        lock_d = BCWB_TEMP_LOCK; // R01
      end
      else
      begin
        lock_d = BCWB_PERM_LOCK; // R01 R03
        vcr_d[LOCK_BIT] = 1'b0; // R02
      end
    end
    else if (writable)
    begin
      if (VCR_LOAD)
      begin
        vcr_d = VCR_WDATA;
        loaded_d = 1'b1; // R21
        act_d = VCR_WDATA; // R08
      end
      else if (NONVOLATILE_CONFIG_REG_PROG)
      begin
        nv_d = nv_q & NONVOLATILE_CONFIG_REG_WDATA; // R07
        if (!loaded_q)
        begin
          vcr_d = nv_q & NONVOLATILE_CONFIG_REG_WDATA; // R06
          loaded_d = 1'b1;
          act_d = nv_q & NONVOLATILE_CONFIG_REG_WDATA;
        end
      end
      else if (NONVOLATILE_CONFIG_REG_ERASE)
      begin
        nv_d = {CFG_W{1'b1}}; // R05 R07
      end
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      vcr_q <= CFG_FACTORY;
      nv_q <= CFG_FACTORY;
      act_q <= CFG_FACTORY;
      loaded_q <= 1'b0; // R21
      lock_q <= BCWB_UNLOCKED;
      init_q <= 1'b1;
    end
    else
    begin
      vcr_q <= vcr_d;
      nv_q <= nv_d;
      act_q <= act_d;
      loaded_q <= loaded_d; // R04
      lock_q <= lock_d;
      init_q <= init_d;
    end
  end

  // The soft reset strobe is deliberately unused here: the selector must survive it.
  assign ACTIVE_CFG = act_q;
  assign VOLATILE_CONFIG_REG = vcr_q;
  assign NONVOLATILE_CONFIG_REG = nv_q;
  assign CONFIG_SOURCE_SELECTOR = loaded_q; // R04 R21
  assign LOCK_STATE = lock_q;

  bcwb_burst_t bst_q, bst_d;
  logic [ADDR_W-1:0] base_q, base_d, off_q, off_d, mask_q, mask_d;
  logic [ADDR_W-1:0] wa_q, wa_d;
  logic lin_q, lin_d, wv_q, wv_d, strb_q, strb_d;
  logic [5:0] cnt_q, cnt_d, lim_q, lim_d;

  always_comb
  begin
    bst_d = bst_q;
    base_d = base_q;
    off_d = off_q;
    mask_d = mask_q;
    lin_d = lin_q;
    cnt_d = cnt_q;
    lim_d = lim_q;
    wa_d = wa_q;
    wv_d = 1'b0;
    strb_d = strb_q;
    unique case (bst_q)
      BCWB_IDLE:
      begin
        if (TXN_START)
        begin
          mask_d = wrap_mask(act_q[BL_HI:BL_LO]); // R19
          base_d = START_ADDR & ~wrap_mask(act_q[BL_HI:BL_LO]);
          off_d = START_ADDR & wrap_mask(act_q[BL_HI:BL_LO]);
          lin_d = BURST_TYPE_CMD_BIT;
          base_d = BURST_TYPE_CMD_BIT ? START_ADDR : base_d; // R09
          off_d = BURST_TYPE_CMD_BIT ? '0 : off_d;
          lim_d = 6'(wrap_mask(act_q[BL_HI:BL_LO])) + 6'h01;
          cnt_d = '0;
          strb_d = 1'b0;
          bst_d = BCWB_BURST;
        end
      end
      BCWB_BURST:
      begin
        if (TXN_END)
        begin
          bst_d = BCWB_IDLE;
        end
        else if (WORD_REQ && !WORD_IDLE) // R13
        begin
          wa_d = lin_q ? (base_q + off_q) : (base_q | (off_q & mask_q)); // R09 R10 R11 R12
          off_d = off_q + 32'h00000001;
          wv_d = 1'b1;
          strb_d = ~strb_q;
          cnt_d = cnt_q + 6'h01;
          if (!lin_q && (cnt_q + 6'h01 == lim_q))
          begin
            bst_d = BCWB_DONE; // R14
          end
        end
      end
      BCWB_DONE:
      begin
        if (TXN_END)
        begin
          bst_d = BCWB_IDLE;
        end
      end
      default:
      begin
        bst_d = BCWB_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      bst_q <= BCWB_IDLE;
      base_q <= '0;
      off_q <= '0;
      mask_q <= '0;
      lin_q <= 1'b0;
      cnt_q <= '0;
      lim_q <= '0;
      wa_q <= '0;
      wv_q <= 1'b0;
      strb_q <= 1'b0;
    end
    else
    begin
      bst_q <= bst_d;
      base_q <= base_d;
      off_q <= off_d;
      mask_q <= mask_d;
      lin_q <= lin_d;
      cnt_q <= cnt_d;
      lim_q <= lim_d;
      wa_q <= wa_d;
      wv_q <= wv_d;
      strb_q <= strb_d;
    end
  end

  assign WORD_ADDR = wa_q;
  assign WORD_VALID = wv_q;
  assign BURST_DONE = (bst_q == BCWB_DONE); // R14
  assign READ_WRITE_STROBE = strb_q; // R13

  bcwb_crc_t cst_q, cst_d;
  logic [ADDR_W-1:0] ca_q, ca_d, ce_q, ce_d;
  logic [CRC_W-1:0] acc_q, acc_d, res_q, res_d;
  logic cav_q, cav_d;

  always_comb
  begin
    cst_d = cst_q;
    ca_d = ca_q;
    ce_d = ce_q;
    acc_d = acc_q;
    res_d = res_q;
    cav_d = 1'b0;
    unique case (cst_q)
      BCWB_CRC_IDLE:
      begin
        if (CRC_GO)
        begin
          ca_d = CRC_START;
          ce_d = CRC_END;
          acc_d = CRC_INIT;
          cav_d = 1'b1;
          cst_d = BCWB_CRC_RUN;
        end
      end
      BCWB_CRC_RUN:
      begin
        cav_d = !CRC_DATA_VALID;
        if (CRC_DATA_VALID)
        begin
          acc_d = crc_step(acc_q, CRC_DATA); // R15
          if (ca_q == ce_q)
          begin
            cst_d = BCWB_CRC_FIN;
          end
          else
          begin
            ca_d = ca_q + 32'h00000001;
            cav_d = 1'b1;
          end
        end
      end
      BCWB_CRC_FIN:
      begin
        res_d = acc_q; // R15
        cst_d = BCWB_CRC_IDLE;
      end
      default:
      begin
        cst_d = BCWB_CRC_IDLE;
      end
    endcase
  end

  // Power loss and hard reset clear the check value; nothing of it is kept.
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      cst_q <= BCWB_CRC_IDLE;
      ca_q <= '0;
      ce_q <= '0;
      acc_q <= '0;
      res_q <= '0; // R17
      cav_q <= 1'b0;
    end
    else
    begin
      cst_q <= cst_d;
      ca_q <= ca_d;
      ce_q <= ce_d;
      acc_q <= acc_d;
      res_q <= res_d;
      cav_q <= cav_d;
    end
  end

  assign CRC_ADDR = ca_q;
  assign CRC_ADDR_VALID = cav_q;
  assign CRC_BUSY = (cst_q != BCWB_CRC_IDLE);
  assign CHECK_VALUE_LOW = res_q[HALF_W-1:0]; // R16
  assign CHECK_VALUE_HIGH = res_q[CRC_W-1:HALF_W]; // R16

endmodule : bcwb_top

// ### bcwb_chk_sva.sv
// Checker for the configuration source and burst sequencing of bcwb_top.
// Assumes it is bound to bcwb_top and sees only that module's ports.
module bcwb_chk
  import bcwb_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic TXN_START,
  input wire logic BURST_TYPE_CMD_BIT,
  input wire logic WORD_IDLE,
  input wire logic VCR_LOAD,
  input wire logic [CFG_W-1:0] VCR_WDATA,
  input wire logic [CFG_W-1:0] ACTIVE_CFG,
  input wire logic [CFG_W-1:0] VOLATILE_CONFIG_REG,
  input wire logic CONFIG_SOURCE_SELECTOR,
  input wire logic [1:0] LOCK_STATE,
  input wire logic [ADDR_W-1:0] WORD_ADDR,
  input wire logic WORD_VALID,
  input wire logic BURST_DONE,
  input wire logic READ_WRITE_STROBE
);
  logic seen_q, lin_q;
  logic [ADDR_W-1:0] last_q, m;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // Reserved length code falls into the 32-byte group.
  assign m = ACTIVE_CFG[1:0] == BL_16 ? MASK_16 : ACTIVE_CFG[1:0] == BL_64 ? MASK_64 : MASK_32;
  always_ff @(posedge REF_CLK)
  begin
    seen_q <= !(RESET || TXN_START) && (seen_q || WORD_VALID);
    if (TXN_START)
      lin_q <= BURST_TYPE_CMD_BIT;
    if (WORD_VALID)
      last_q <= WORD_ADDR;
  end
  sequence s_lin_word;
    WORD_VALID && seen_q && lin_q;
  endsequence
  sequence s_wrap_word;
    WORD_VALID && seen_q && !lin_q;
  endsequence
  a_idle_no_strobe: assert property (WORD_IDLE |=> $stable(READ_WRITE_STROBE))
    else $error("strobe moved in idle cycle");
  a_word_toggles: assert property (WORD_VALID |->
    READ_WRITE_STROBE != $past(READ_WRITE_STROBE))
    else $error("word without strobe edge");
  a_locked_refuse: assert property (LOCK_STATE != 2'h0 && VCR_LOAD |=>
    $stable(VOLATILE_CONFIG_REG))
    else $error("locked register changed");
  a_vcr_load_now: assert property (LOCK_STATE == 2'h0 && VCR_LOAD |=>
    CONFIG_SOURCE_SELECTOR && ACTIVE_CFG == $past(VCR_WDATA))
    else $error("volatile load not in effect");
  a_sel_sticky: assert property (CONFIG_SOURCE_SELECTOR |=> CONFIG_SOURCE_SELECTOR)
    else $error("source fell back");
  a_linear_next: assert property (s_lin_word |-> WORD_ADDR == last_q + 32'h00000001)
    else $error("linear address skipped");
  a_wrap_next: assert property (s_wrap_word |->
    WORD_ADDR == (((last_q + 32'h00000001) & m) | (last_q & ~m)))
    else $error("wrap address wrong");
  // The last word of a group leaves together with the done flag, so only later cycles are empty.
  a_done_no_word: assert property (BURST_DONE |=> !WORD_VALID)
    else $error("word after burst end");
endmodule : bcwb_chk
bind bcwb_top bcwb_chk chk_u (.*);

// ### bcwb_host.sv
// Host model that paces word requests of a read burst.
// Assumes the bench raises go once the burst is opened.
module bcwb_host
  import bcwb_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic go,
  input wire logic stall,
  input wire logic [7:0] n,
  output logic WORD_REQ,
  output logic WORD_IDLE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  initial
  begin
    WORD_REQ = 1'b0;
    WORD_IDLE = 1'b0;
    cnt = 8'h00;
  end
  // Idle cycles are counted out so the host asks for exactly n words.
  always @(posedge REF_CLK)
  begin
    #1;
    if (!go)
      cnt = 8'h00;
    WORD_REQ = go && cnt < n;
    WORD_IDLE = WORD_REQ && stall && ($urandom % 3 == 0);
    if (WORD_REQ && !WORD_IDLE)
      cnt++;
  end
endmodule : bcwb_host

// ### testbench.sv
// Bench for bursts, configuration source, locking and the check value.
// Assumes bcwb_host paces words and this bench supplies check-value data.
module testbench;
  import bcwb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic REF_CLK, RESET, SOFT_RESET, VCR_LOAD, NONVOLATILE_CONFIG_REG_PROG, NONVOLATILE_CONFIG_REG_ERASE, TXN_START, TXN_END;
  logic BURST_TYPE_CMD_BIT, WORD_REQ, WORD_IDLE, CRC_GO, CRC_DATA_VALID, go, stall;
  logic CONFIG_SOURCE_SELECTOR, WORD_VALID, BURST_DONE, READ_WRITE_STROBE;
  logic CRC_ADDR_VALID, CRC_BUSY;
  logic [CFG_W-1:0] NV_STORED, VCR_WDATA, NONVOLATILE_CONFIG_REG_WDATA, ACTIVE_CFG, VOLATILE_CONFIG_REG;
  logic [CFG_W-1:0] NONVOLATILE_CONFIG_REG, CRC_DATA, CHECK_VALUE_LOW, CHECK_VALUE_HIGH;
  logic [ADDR_W-1:0] START_ADDR, CRC_START, CRC_END, WORD_ADDR, CRC_ADDR, ca;
  logic [CRC_W-1:0] crc_x;
  logic [1:0] LOCK_STATE;
  logic [7:0] n;
  logic [ADDR_W-1:0] exp_q[$];
  int fail_count, checks;
  bcwb_top dut_u (.*);
  bcwb_host host_u (.*);
  initial
  begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  task automatic tick;
    @(posedge REF_CLK);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick;
    s = 1'b0;
    tick;
  endtask : pulse
  task automatic wr(ref logic s, input logic [15:0] v);
    VCR_WDATA = v;
    NONVOLATILE_CONFIG_REG_WDATA = v;
    pulse(s);
  endtask : wr
  task automatic do_reset(input logic [15:0] nv);
    NV_STORED = nv;
    RESET = 1'b1;
    repeat (8) tick;
    RESET = 1'b0;
    tick;
    tick;
  endtask : do_reset
  // Wrap bursts ask for two words too many; the surplus must yield nothing.
  task automatic burst(input logic lin, input logic [1:0] bl, input logic st);
    logic [ADDR_W-1:0] a, m;
    a = $urandom & 32'h00ffffff;
    m = bl == BL_16 ? MASK_16 : bl == BL_64 ? MASK_64 : MASK_32;
    n = lin ? 8'h28 : m[7:0] + 8'h01;
    for (int i = 0; i < n; i++)
      exp_q.push_back(lin ? a + i : (a & ~m) | ((a + i) & m));
    if (!lin)
      n = n + 8'h02;
    START_ADDR = a;
    BURST_TYPE_CMD_BIT = lin;
    pulse(TXN_START);
    stall = st;
    go = 1'b1;
    for (int k = 0; k < 300 && exp_q.size() > 0; k++)
      tick;
    repeat (6) tick;
    chk("words left", exp_q.size(), 0);
    if (!lin)
      chk("burst done", BURST_DONE, 1'b1);
    else
      chk("burst done", BURST_DONE, 1'b0);
    go = 1'b0;
    pulse(TXN_END);
  endtask : burst
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h00000000);
    return c;
  endfunction : crc_step
  // Words are looked at mid-cycle, well away from the edge that launches them.
  always @(negedge REF_CLK)
    if (WORD_VALID === 1'b1)
      chk("word address", WORD_ADDR, exp_q.size() ? exp_q.pop_front() : 32'hx);
  always @(posedge REF_CLK)
  begin
    #1;
    CRC_DATA_VALID = CRC_ADDR_VALID === 1'b1;
    if (CRC_ADDR_VALID === 1'b1)
    begin
      chk("crc address", CRC_ADDR, ca);
      ca++;
      CRC_DATA = 16'($urandom);
      crc_x = crc_step(crc_x, CRC_DATA);
    end
  end
  initial
  begin
    #200000;
    fail_count++;
    results;
  end
  initial
  begin
    {SOFT_RESET, VCR_LOAD, NONVOLATILE_CONFIG_REG_PROG, NONVOLATILE_CONFIG_REG_ERASE, TXN_START, TXN_END, CRC_GO} = '0;
    {BURST_TYPE_CMD_BIT, CRC_DATA_VALID, go, stall, n, ca, crc_x} = '0;
    {VCR_WDATA, NONVOLATILE_CONFIG_REG_WDATA, CRC_DATA, START_ADDR, CRC_START, CRC_END} = '0;
    fail_count = 0;
    checks = 0;
    void'($urandom(65));
    do_reset(CFG_FACTORY);
    chk("lock", LOCK_STATE, 2'h0);
    chk("source", CONFIG_SOURCE_SELECTOR, 1'b0);
    chk("active", ACTIVE_CFG, CFG_FACTORY);
    chk("check low", CHECK_VALUE_LOW, 16'h0000);
    burst(1'b0, BL_32, 1'b0);
    wr(NONVOLATILE_CONFIG_REG_PROG, 16'hbf8a);
    chk("volatile", VOLATILE_CONFIG_REG, 16'hbf8a);
    wr(VCR_LOAD, 16'hbf89);
    chk("source", CONFIG_SOURCE_SELECTOR, 1'b1);
    wr(NONVOLATILE_CONFIG_REG_PROG, 16'hbf88);
    chk("volatile", VOLATILE_CONFIG_REG, 16'hbf89);
    chk("active", ACTIVE_CFG, 16'hbf89);
    pulse(NONVOLATILE_CONFIG_REG_ERASE);
    chk("nonvolatile", NONVOLATILE_CONFIG_REG, 16'hffff);
    pulse(SOFT_RESET);
    chk("source", CONFIG_SOURCE_SELECTOR, 1'b1);
    burst(1'b0, BL_64, 1'b1);
    burst(1'b1, BL_64, 1'b1);
    wr(VCR_LOAD, 16'hbf8a);
    burst(1'b0, BL_16, 1'b0);
    CRC_START = 32'h00000004;
    CRC_END = 32'h00000005;
    ca = CRC_START;
    crc_x = CRC_INIT;
    pulse(CRC_GO);
    for (int k = 0; k < 50 && CRC_BUSY !== 1'b0; k++)
      tick;
    repeat (3) tick;
    chk("crc words", ca, 32'h00000006);
    chk("check low", CHECK_VALUE_LOW, crc_x[15:0]);
    chk("check high", CHECK_VALUE_HIGH, crc_x[31:16]);
    wr(NONVOLATILE_CONFIG_REG_PROG, 16'hf7ff);
    wr(VCR_LOAD, 16'hbf8b);
    chk("active", ACTIVE_CFG, 16'hbf8b);
    do_reset(16'hb78b);
    chk("lock", LOCK_STATE, 2'h3);
    chk("check high", CHECK_VALUE_HIGH, 16'h0000);
    wr(VCR_LOAD, 16'hbf8a);
    chk("volatile", VOLATILE_CONFIG_REG, 16'hb78b);
    results;
  end
endmodule : testbench
